// [src/ldc_pkg.sv]
package ldc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam logic [7:0]  OFF_DRV_A     = 8'h23;
  localparam logic [7:0]  OFF_DRV_B     = 8'h24;
  localparam logic [7:0]  OFF_FINE      = 8'h25;
  localparam logic [15:0] DRV_RST       = 16'h3000;
  localparam logic [15:0] FINE_RST      = 16'h030C;
  localparam logic [15:0] FINE_MASK     = 16'h07DF;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          STRENGTH_BIT  = 13;
  localparam int          SLEW_HI       = 6;
  localparam int          SLEW_LO       = 4;
  localparam int          COARSE_HI     = 3;
  localparam int          COARSE_LO     = 0;
  localparam int          FINE_A_HI     = 4;
  localparam int          FINE_A_LO     = 0;
  localparam int          FINE_B_HI     = 10;
  localparam int          FINE_B_LO     = 6;
  localparam logic [4:0]  FINE_RST_CODE = 5'h0C;
  // ----------------------------------------------------------------
  // peak target terms, fixed point: coarse x100 mA, fine x1000, scale x10
  // ----------------------------------------------------------------
  localparam logic [14:0] COARSE_BASE   = 15'h0AF0;
  localparam logic [10:0] COARSE_STEP   = 11'h060A;
  localparam logic [10:0] FINE_BASE     = 11'h02C6;
  localparam logic [4:0]  FINE_STEP     = 5'h18;
  localparam logic [3:0]  SCALE_LOW     = 4'h4;
  localparam logic [3:0]  SCALE_FULL    = 4'hA;
  localparam int          PEAK_W        = 29;
endpackage

// [src/ldc_drv_if.sv]
`timescale 1ns/100ps
interface ldc_drv_if;
  import ldc_pkg::*;
  logic              strength;
  logic [3:0]        coarse;
  logic [4:0]        fine;
  logic [PEAK_W-1:0] peak;
  modport cfg  (output strength, output coarse, output fine, input peak);
  modport calc (input strength, input coarse, input fine, output peak);
endinterface

// [src/ldc_peak_calc.sv]
`timescale 1ns/100ps
module ldc_peak_calc
  import ldc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  ldc_drv_if.calc   drv
);
  logic [14:0] coarse_term;
  logic [10:0] fine_term;
  logic [3:0]  scale_term;
  logic [29:0] product;

  // ----------------------------------------------------------------
  // peak target in nA: coarse x fine x scale
  // ----------------------------------------------------------------
  always_comb
  begin
    // operands widened first so the step product cannot wrap at its own width
    coarse_term = COARSE_BASE + 15'(COARSE_STEP) * 15'(drv.coarse);
    fine_term   = FINE_BASE + 11'(FINE_STEP) * 11'(drv.fine);
    scale_term  = drv.strength ? SCALE_FULL : SCALE_LOW;
    product     = 30'(coarse_term) * 30'(fine_term) * 30'(scale_term);
  end

  // registered so the long multiply sits alone in its path
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      drv.peak <= '0;
    else
      drv.peak <= product[PEAK_W-1:0];
  end

  // the edge that releases reset still samples reset low, so no check starts there
  AST_PEAK_FORMULA: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    resetn_i |=> drv.peak == 29'((30'd2800 + 30'd1546 * $past(drv.coarse)) * (30'd710 + 30'd24 * $past(drv.fine))
                   * ($past(drv.strength) ? 30'd10 : 30'd4)))
    else $error("peak target does not follow coarse, fine and scale");
endmodule // ldc_peak_calc

// [src/ldc_top.sv]
`timescale 1ns/100ps
// Operation
// - bit 13 sets driver A full or 40%
// - bit 13 sets driver B full or 40%
// - bits 6:4 select driver A slew
// - bits 6:4 select driver B slew
// - bits 3:0 set driver A coarse current
// - bits 3:0 set driver B coarse current
// - driver A peak is coarse, fine, scale product
// - driver B peak uses fine bits 10:6
// - fine fields at 4:0, 10:6, reset 0xC
module ldc_top
  import ldc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              wr_en_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic                   rd_valid_o,
  output logic                   drv_a_strength_sel_o,
  output logic      [2:0]        drv_a_slew_sel_o,
  output logic      [3:0]        drv_a_coarse_code_o,
  output logic      [4:0]        drv_a_fine_trim_o,
  output logic                   drv_b_strength_sel_o,
  output logic      [2:0]        drv_b_slew_sel_o,
  output logic      [3:0]        drv_b_coarse_code_o,
  output logic      [4:0]        drv_b_fine_trim_o,
  output logic      [PEAK_W-1:0] drv_a_peak_na_o,
  output logic      [PEAK_W-1:0] drv_b_peak_na_o
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [DATA_W-1:0] drv_reg [2];
  logic [DATA_W-1:0] fine_reg;
  logic [ADDR_W-1:0] drv_off [2];

  assign drv_off[0] = OFF_DRV_A;
  assign drv_off[1] = OFF_DRV_B;

  // ----------------------------------------------------------------
  // driver setting registers
  // ----------------------------------------------------------------
  // reserved bits are stored as written; a bad write is visible on read-back
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_drv
      always_ff @(posedge ref_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          drv_reg[g] <= DRV_RST;
        else if (wr_en_i && hit(addr_i, drv_off[g]))
          drv_reg[g] <= wr_data_i;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared fine adjust register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      fine_reg <= FINE_RST;
    else if (wr_en_i && hit(addr_i, OFF_FINE))
      fine_reg <= wr_data_i & FINE_MASK;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i)
      begin
        if (hit(addr_i, OFF_DRV_A))
          rd_data_o <= drv_reg[0];
        else if (hit(addr_i, OFF_DRV_B))
          rd_data_o <= drv_reg[1];
        else if (hit(addr_i, OFF_FINE))
          rd_data_o <= fine_reg;
        else
          rd_data_o <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // driver controls, taken straight from the registers
  // ----------------------------------------------------------------
  assign drv_a_strength_sel_o = drv_reg[0][STRENGTH_BIT];
  assign drv_b_strength_sel_o = drv_reg[1][STRENGTH_BIT];
  assign drv_a_slew_sel_o     = drv_reg[0][SLEW_HI:SLEW_LO];
  assign drv_b_slew_sel_o     = drv_reg[1][SLEW_HI:SLEW_LO];
  assign drv_a_coarse_code_o  = drv_reg[0][COARSE_HI:COARSE_LO];
  assign drv_b_coarse_code_o  = drv_reg[1][COARSE_HI:COARSE_LO];
  assign drv_a_fine_trim_o    = fine_reg[FINE_A_HI:FINE_A_LO];
  assign drv_b_fine_trim_o    = fine_reg[FINE_B_HI:FINE_B_LO];

  // ----------------------------------------------------------------
  // peak target per driver
  // ----------------------------------------------------------------
  ldc_drv_if drv_a ();
  ldc_drv_if drv_b ();

  assign drv_a.strength  = drv_a_strength_sel_o;
  assign drv_a.coarse    = drv_a_coarse_code_o;
  assign drv_a.fine      = drv_a_fine_trim_o;
  assign drv_b.strength  = drv_b_strength_sel_o;
  assign drv_b.coarse    = drv_b_coarse_code_o;
  assign drv_b.fine      = drv_b_fine_trim_o;
  assign drv_a_peak_na_o = drv_a.peak;
  assign drv_b_peak_na_o = drv_b.peak;

  ldc_peak_calc u_calc_a (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .drv       (drv_a.calc)
  );

  ldc_peak_calc u_calc_b (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .drv       (drv_b.calc)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_STRENGTH_A: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h23 |=> drv_a_strength_sel_o == $past(wr_data_i[13]))
    else $error("driver A strength does not follow bit 13");
  AST_STRENGTH_B: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h24 |=> drv_b_strength_sel_o == $past(wr_data_i[13]))
    else $error("driver B strength does not follow bit 13");
  AST_SLEW_A: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h23 |=> drv_a_slew_sel_o == $past(wr_data_i[6:4]) && drv_b_slew_sel_o == $past(drv_b_slew_sel_o))
    else $error("driver A slew does not follow bits 6:4");
  AST_SLEW_B: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h24 |=> drv_b_slew_sel_o == $past(wr_data_i[6:4]) && drv_a_slew_sel_o == $past(drv_a_slew_sel_o))
    else $error("driver B slew does not follow bits 6:4");
  AST_COARSE_A: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h23 |=> drv_a_coarse_code_o == $past(wr_data_i[3:0]))
    else $error("driver A coarse does not follow bits 3:0");
  AST_COARSE_B: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h24 |=> drv_b_coarse_code_o == $past(wr_data_i[3:0]))
    else $error("driver B coarse does not follow bits 3:0");
  AST_FINE_B: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h25 |=> drv_b_fine_trim_o == $past(wr_data_i[10:6]))
    else $error("driver B fine trim does not follow bits 10:6");
  AST_FINE_A: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h25 |=> drv_a_fine_trim_o == $past(wr_data_i[4:0]))
    else $error("driver A fine trim does not follow bits 4:0");
  AST_PEAK_A_LAG: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == 8'h23 && wr_data_i[13] == 1'b1 && wr_data_i[3:0] == 4'h0 && !$past(wr_en_i)
    ##1 !wr_en_i |-> ##1 drv_a_peak_na_o == 29'(30'd28000 * (30'd710 + 30'd24 * drv_a_fine_trim_o)))
    else $error("driver A peak at coarse 0 full strength is wrong");
  AST_PEAK_B_LAG: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_en_i && addr_i == OFF_DRV_B && !wr_data_i[STRENGTH_BIT] && wr_data_i[COARSE_HI:COARSE_LO] == 4'h0
    ##1 !wr_en_i |-> ##1 drv_b_peak_na_o == 29'(30'h2BC0 * (30'h02C6 + 30'h0018 * drv_b_fine_trim_o)))
    else $error("driver B peak at coarse 0 reduced strength is wrong");

  // ----------------------------------------------------------------
  // read port and hold checks
  // ----------------------------------------------------------------
  // a write beside the read moves the controls on the same edge that captures the old read data, so those cycles are left out
  AST_RD_A: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_en_i && !wr_en_i && addr_i == OFF_DRV_A
    |=> rd_data_o[STRENGTH_BIT] == drv_a_strength_sel_o && rd_data_o[SLEW_HI:SLEW_LO] == drv_a_slew_sel_o
        && rd_data_o[COARSE_HI:COARSE_LO] == drv_a_coarse_code_o)
    else $error("driver A read-back differs from its controls");
  AST_RD_B: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_en_i && !wr_en_i && addr_i == OFF_DRV_B
    |=> rd_data_o[STRENGTH_BIT] == drv_b_strength_sel_o && rd_data_o[SLEW_HI:SLEW_LO] == drv_b_slew_sel_o
        && rd_data_o[COARSE_HI:COARSE_LO] == drv_b_coarse_code_o)
    else $error("driver B read-back differs from its controls");
  AST_RD_FINE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_en_i && !wr_en_i && addr_i == OFF_FINE
    |=> rd_data_o[FINE_A_HI:FINE_A_LO] == drv_a_fine_trim_o && rd_data_o[FINE_B_HI:FINE_B_LO] == drv_b_fine_trim_o
        && (rd_data_o & ~FINE_MASK) == 16'h0000)
    else $error("fine adjust read-back differs from the trims");
  AST_RD_UNMAPPED: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_en_i && addr_i != OFF_DRV_A && addr_i != OFF_DRV_B && addr_i != OFF_FINE
    |=> rd_data_o == 16'h0000)
    else $error("unmapped read does not return zero");
  AST_RD_VALID: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_en_i |=> rd_valid_o)
    else $error("read valid missing after a read strobe");
  AST_RD_VALID_DROP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !rd_en_i |=> !rd_valid_o)
    else $error("read valid without a read strobe");
  AST_RD_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  // controls move only on a write to their own register
  AST_HOLD_A: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(wr_en_i && addr_i == OFF_DRV_A)
    |=> $stable(drv_a_strength_sel_o) && $stable(drv_a_slew_sel_o) && $stable(drv_a_coarse_code_o))
    else $error("driver A controls moved without a write");
  AST_HOLD_B: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(wr_en_i && addr_i == OFF_DRV_B)
    |=> $stable(drv_b_strength_sel_o) && $stable(drv_b_slew_sel_o) && $stable(drv_b_coarse_code_o))
    else $error("driver B controls moved without a write");
  AST_HOLD_FINE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(wr_en_i && addr_i == OFF_FINE)
    |=> $stable(drv_a_fine_trim_o) && $stable(drv_b_fine_trim_o))
    else $error("fine trims moved without a write");
endmodule // ldc_top

// [tb/test_led_drive_current_config.sv]
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_led_drive_current_config
  import ldc_pkg::*;
();
  logic              ref_clk_i = 1'b0;
  logic              resetn_i  = 1'b0;
  logic [ADDR_W-1:0] addr_i    = 8'h00;
  logic              wr_en_i   = 1'b0;
  logic [DATA_W-1:0] wr_data_i = 16'h0000;
  logic              rd_en_i   = 1'b0;
  logic [DATA_W-1:0] rd_data_o;
  logic              rd_valid_o;
  logic              a_str, b_str;
  logic [2:0]        a_slew, b_slew;
  logic [3:0]        a_crs, b_crs;
  logic [4:0]        a_fin, b_fin;
  logic [PEAK_W-1:0] a_pk, b_pk;
  int                errors = 0;
  int                samples_checked = 0;

  ldc_top dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .drv_a_strength_sel_o(a_str), .drv_a_slew_sel_o(a_slew), .drv_a_coarse_code_o(a_crs),
    .drv_a_fine_trim_o(a_fin), .drv_b_strength_sel_o(b_str), .drv_b_slew_sel_o(b_slew),
    .drv_b_coarse_code_o(b_crs), .drv_b_fine_trim_o(b_fin), .drv_a_peak_na_o(a_pk), .drv_b_peak_na_o(b_pk));

  always #10 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // peak in nA, worked out in integers so no rounding creeps in
  function automatic logic [PEAK_W-1:0] pk(input int c, input int f, input int s);
    return PEAK_W'((2800 + 1546 * c) * (710 + 24 * f) * (s != 0 ? 10 : 4));
  endfunction

  task automatic settle();
    @(posedge ref_clk_i);
    #1;
  endtask

  // peak lags the controls by one edge, so settle once before checking it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_en_i   <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b0;
    settle();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid_o)
    `CHK("rd_data", exp, rd_data_o)
    settle();
    `CHK("rd_valid_drop", 1'b0, rd_valid_o)
    `CHK("rd_data_hold", exp, rd_data_o)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK("a_str", 1'b1, a_str)
    `CHK("a_slew", 3'h0, a_slew)
    `CHK("a_fine", 5'h0C, a_fin)
    `CHK("b_fine", 5'h0C, b_fin)
    `CHK("a_peak", pk(0, 12, 1), a_pk)
    `CHK("a_coarse", 4'h0, a_crs)
    `CHK("b_str", 1'b1, b_str)
    `CHK("b_slew", 3'h0, b_slew)
    `CHK("b_coarse", 4'h0, b_crs)
    `CHK("b_peak", pk(0, 12, 1), b_pk)
    rd_chk(8'h23, 16'h3000);
    rd_chk(8'h24, 16'h3000);
    rd_chk(8'h25, 16'h030C);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h23, 16'h3000 | 16'(c));
      `CHK("a_coarse", 4'(c), a_crs)
      `CHK("a_peak", pk(c, 12, 1), a_pk)
    end
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h24, 16'h1000 | 16'(s << 4) | 16'(s));
      `CHK("b_slew", 3'(s), b_slew)
      `CHK("b_coarse", 4'(s), b_crs)
      `CHK("b_str", 1'b0, b_str)
      `CHK("b_peak", pk(s, 12, 0), b_pk)
    end
  endtask

  task automatic t_drv_a_and_fine();
    wr(8'h23, 16'h1075);
    `CHK("a_str", 1'b0, a_str)
    `CHK("a_slew", 3'h7, a_slew)
    `CHK("a_peak", pk(5, 12, 0), a_pk)
    `CHK("b_slew", 3'h7, b_slew)
    wr(8'h25, 16'hFFFF);
    `CHK("a_peak", pk(5, 31, 0), a_pk)
    `CHK("b_peak", pk(7, 31, 0), b_pk)
    rd_chk(8'h25, 16'h07DF);
    wr(8'h25, 16'h0143);
    `CHK("a_fine", 5'h03, a_fin)
    `CHK("b_fine", 5'h05, b_fin)
    wr(8'h26, 16'hFFFF);
    rd_chk(8'h26, 16'h0000);
    rd_chk(8'h23, 16'h1075);
    rd_chk(8'h24, 16'h1077);
  endtask

  // reset in mid-run must bring every register back to its default
  task automatic t_midrun_reset();
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    #1;
    `CHK("a_str_in_rst", 1'b1, a_str)
    `CHK("rd_data_in_rst", 16'h0000, rd_data_o)
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    settle();
    settle();
    t_reset();
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    settle();
    settle();
    t_reset();
    t_codes();
    t_drv_a_and_fine();
    t_midrun_reset();
    tally_and_finish();
  end
endmodule // test_led_drive_current_config
